// [hw/sram_ctrl.sv]
// Host controller that runs read and write cycles on an asynchronous byte-wide memory.
`timescale 1ns/1ns
`include "sram_ctrl_regs.svh"
module sram_ctrl #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input sram_ctrl_pkg::req_type REQ_I,
  input wire logic WAKE_I,
  output logic RDATA_VALID_O,
  output logic [7:0] RDATA_O,
  output logic [18:0] ADDR_BUS_O,
  output logic CS_N_O,
  output logic WE_N_O,
  output logic OE_N_O,
  input wire logic [7:0] DATA_BUS_I,
  output logic [7:0] DATA_BUS_O,
  output logic DATA_BUS_OE_O
);
  import sram_ctrl_pkg::*;

  // The pin widths are fixed by the memory, so other widths are refused at elaboration.
  if (ADDR_W != 19 || DATA_W != 8) begin : g_bad_widths
    $error("sram_ctrl serves only a 19-bit address and 8-bit data");
  end

  state_type state_q, state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [18:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic cs_n_q, we_n_q, oe_n_q, drive_q;

  wire idle = (state_q == ST_IDLE);
  wire take = idle && REQ_VALID_I && !WAKE_I;
  wire cnt_done = (cnt_q == 4'h0);
  wire [3:0] c_read = 4'(`READ_SAMPLE_CYCLES - 1);
  wire [3:0] c_turn = 4'(`TURN_CYCLES - 1);
  wire [3:0] c_wpulse = 4'(`WRITE_PULSE_CYCLES - 1);
  // A write fills out its cycle time after the pulse before the next access may start.
  wire [3:0] c_wrec = 4'(`WRITE_CYCLES - `WRITE_PULSE_CYCLES);
  wire [3:0] c_recov = 4'(`RECOVERY_CYCLES - 1);

  // Requests are refused while the memory sits in retention standby.
  assign REQ_READY_O = idle && !WAKE_I;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? 4'h0 : cnt_q - 4'h1;
    case (state_q)
      ST_IDLE: begin
        if (WAKE_I) begin
          state_d = ST_RECOV;
          cnt_d = c_recov;
        end else if (take && REQ_I.write) begin
          state_d = ST_TURN;
          cnt_d = c_turn;
        end else if (take) begin
          state_d = ST_READ;
          cnt_d = c_read;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_TURN: begin
        if (cnt_done) begin
          state_d = ST_WRITE;
          cnt_d = c_wpulse;
        end
      end
      ST_WRITE: begin
        if (cnt_done) begin
          state_d = ST_WREC;
          cnt_d = c_wrec;
        end
      end
      ST_WREC: begin
        // The drive stays on here so that data hold past the strobe rise is met.
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_RECOV: begin
        if (WAKE_I) begin
          cnt_d = c_recov;
        end else if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  wire cs_n_d = !(state_d == ST_READ || state_d == ST_TURN || state_d == ST_WRITE);
  wire we_n_d = !(state_d == ST_WRITE);
  wire oe_n_d = !(state_d == ST_READ);
  wire drive_d = (state_d == ST_WRITE) || (state_d == ST_WREC);
  // Sampling one cycle past the access delay trades a little speed for settling margin.
  // sample at last read cycle.
  wire sample = (state_q == ST_READ) && cnt_done;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      drive_q <= drive_d;
    end
  end

  // data and address held past strobe rise.
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      addr_q <= 19'h0_0000;
      wdata_q <= 8'h00;
    end else if (take) begin
      addr_q <= REQ_I.addr;
      wdata_q <= REQ_I.wdata;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= sample;
      if (sample) begin
        rdata_q <= DATA_BUS_I;
      end
    end
  end

  assign ADDR_BUS_O = addr_q;
  assign CS_N_O = cs_n_q;
  assign WE_N_O = we_n_q;
  assign OE_N_O = oe_n_q;
  // Drive stays on two cycles after the strobe rises so hold against the ending edge is met.
  assign DATA_BUS_OE_O = drive_q;
  assign DATA_BUS_O = wdata_q;
  assign RDATA_O = rdata_q;
  assign RDATA_VALID_O = rvalid_q;

  // Counts the cycles of an open read, for the access-delay assertion only.
  logic [4:0] low_cnt_q;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      low_cnt_q <= 5'h00;
    end else if (!CS_N_O && !OE_N_O) begin
      low_cnt_q <= low_cnt_q + 5'h01;
    end else begin
      low_cnt_q <= 5'h00;
    end
  end

  a_read_sample_time: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    sample |-> (low_cnt_q >= 5'(`READ_SAMPLE_CYCLES - 1)))
    else $error("read sampled before access delay");
  a_no_bus_fight: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    !(DATA_BUS_OE_O && !OE_N_O))
    else $error("bus driven while memory output enabled");
  a_write_oe_high: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    !WE_N_O |-> OE_N_O)
    else $error("output enable low during write");
  a_write_pulse_len: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    $fell(WE_N_O) |-> !WE_N_O [*8] ##1 WE_N_O)
    else $error("write pulse length wrong");
  a_addr_stable_wr: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (!WE_N_O || DATA_BUS_OE_O) |-> $stable(ADDR_BUS_O))
    else $error("address changed during write");
  a_data_during_we: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    !WE_N_O |-> DATA_BUS_OE_O && !CS_N_O)
    else $error("write strobe without driven data");
  a_read_spacing: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    $fell(OE_N_O) |-> !OE_N_O [*8] ##1 !OE_N_O)
    else $error("read cycle too short");
  a_recovery_wait: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    $fell(WAKE_I) |-> CS_N_O [*8])
    else $error("access started before recovery wait");
  a_turn_before_drive: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    $rose(DATA_BUS_OE_O) |-> OE_N_O && $past(OE_N_O, 1) && $past(OE_N_O, 2)
      && $past(OE_N_O, 3) && $past(OE_N_O, 4))
    else $error("bus driven before turnaround");
  a_write_data_hold: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    $rose(WE_N_O) |-> DATA_BUS_OE_O && $stable(DATA_BUS_O))
    else $error("write data released at strobe rise");
  a_ready_recovery: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    $fell(WAKE_I) |-> !REQ_READY_O [*8])
    else $error("request accepted during recovery wait");
  a_rdata_pulse: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    RDATA_VALID_O |=> !RDATA_VALID_O)
    else $error("read data valid longer than one cycle");
  a_read_strobes: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    !OE_N_O |-> WE_N_O && !CS_N_O)
    else $error("output enable low outside a read");
endmodule

// [hw/sram_ctrl_regs.svh]
// Timing figures and cycle counts for the asynchronous byte-wide memory controller.
`ifndef SRAM_CTRL_REGS_SVH
`define SRAM_CTRL_REGS_SVH
`define CLK_PERIOD_NS 8
`define READ_CYCLE_TIME_NS 70
`define ADDR_ACCESS_DELAY_NS 70
`define OE_ACCESS_DELAY_NS 35
`define ADDR_CHANGE_DATA_HOLD_NS 10
`define ADDR_SETUP_TO_WRITE_END_NS 60
`define WRITE_STROBE_FLOAT_DELAY_NS 25
`define WRITE_DATA_SETUP_NS 30
`define OE_FLOAT_DELAY_NS 25
`define WRITE_CYCLE_TIME_NS 70
`define CDIV_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES `CDIV_UP(`READ_CYCLE_TIME_NS)
`define READ_SAMPLE_CYCLES (`CDIV_UP(`ADDR_ACCESS_DELAY_NS) + 1)
`define WRITE_PULSE_CYCLES `CDIV_UP(`ADDR_SETUP_TO_WRITE_END_NS)
`define WRITE_CYCLES `CDIV_UP(`WRITE_CYCLE_TIME_NS)
`define TURN_CYCLES `CDIV_UP(`OE_FLOAT_DELAY_NS)
`define RECOVERY_CYCLES `CDIV_UP(`READ_CYCLE_TIME_NS)
`endif

// [hw/sram_ctrl_pkg.sv]
// Types shared by the memory controller.
package sram_ctrl_pkg;
  typedef struct packed {
    logic write;
    logic [18:0] addr;
    logic [7:0] wdata;
  } req_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_TURN = 3'b010,
    ST_WRITE = 3'b011,
    ST_WREC = 3'b100,
    ST_RECOV = 3'b101
  } state_type;
endpackage

// [test/sram_model.sv]
// Behavioural model of the asynchronous byte-wide memory.
`timescale 1ns/1ns
module sram_model (
  input wire logic [18:0] addr_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] rd_q = 8'h00;
  wire wr_on = !cs_n_i && !we_n_i;
  wire rd_on = !cs_n_i && we_n_i && !oe_n_i;
  // store at end of overlap
  // Only a true high-to-low end of the overlap stores, so strobes settling at reset write nothing.
  logic wr_was = 1'b0;
  always @(wr_on) begin
    if (wr_was && wr_on === 1'b0) begin
      mem[addr_i] = data_i;
    end
    wr_was = (wr_on === 1'b1);
  end
  // old data kept 10 ns, new data valid after 70 ns
  always @(addr_i or rd_on) begin
    rd_q <= #10 ~rd_q;
    rd_q <= #70 (mem.exists(addr_i) ? mem[addr_i] : ~rd_q);
  end
  // floating bus shows a changing pattern
  assign data_o = rd_on ? rd_q : ~rd_q;
endmodule

// [test/tb_top.sv]
// Self-checking bench for the memory controller.
`timescale 1ns/1ns
module tb_top;
  import sram_ctrl_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, valid = 1'b0, wake = 1'b0;
  req_type req = '0;
  logic ready, rvalid, cs_n, we_n, oe_n, doe;
  logic [7:0] rdata, dout, din, mdq;
  logic [18:0] addr;
  logic [7:0] expq [$];
  logic [7:0] ref_mem [logic [18:0]];
  logic [18:0] alist [8];
  int n_fail = 0, checked = 0, cyc = 0, n;
  assign din = doe ? dout : mdq;
  sram_ctrl i_dut (.SYS_CLK_I(clk), .NRST_I(nrst), .REQ_VALID_I(valid), .REQ_READY_O(ready),
    .REQ_I(req), .WAKE_I(wake), .RDATA_VALID_O(rvalid), .RDATA_O(rdata), .ADDR_BUS_O(addr),
    .CS_N_O(cs_n), .WE_N_O(we_n), .OE_N_O(oe_n), .DATA_BUS_I(din), .DATA_BUS_O(dout),
    .DATA_BUS_OE_O(doe));
  sram_model i_mem (.addr_i(addr), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .data_i(din), .data_o(mdq));
  initial forever #4 clk = ~clk;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The expected byte is noted when the request is handed over.
  task automatic issue(input logic w, input logic [18:0] a, input logic [7:0] d);
    @(negedge clk);
    valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    if (w) ref_mem[a] = d;
    else expq.push_back(ref_mem[a]);
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
  endtask
  always @(negedge clk) begin
    if (rvalid === 1'b1 && expq.size() == 0) cmp("rdata unexpected", 1'b0, 1'b1);
    else if (rvalid === 1'b1) cmp("rdata", expq.pop_front(), rdata);
    if (nrst) cmp("bus clash", 1'b0, doe & ~oe_n);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'heb8d_eb26));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      alist[i] = (i == 0) ? 19'h0_0000 : (i == 1) ? 19'h7_ffff : 19'($urandom);
      issue(1'b1, alist[i], 8'($urandom));
    end
    // Overwrite a boundary location, then read everything back to back.
    issue(1'b1, alist[1], ~ref_mem[alist[1]]);
    for (int i = 0; i < 8; i++) issue(1'b0, alist[i], 8'h00);
    repeat (15) @(negedge clk);
    wake = 1'b1;
    repeat (3) @(negedge clk);
    cmp("ready in standby", 1'b0, ready);
    wake = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 50);
    cmp("recovery wait", 1'b1, n >= 9);
    cmp("ready after recovery", 1'b1, ready);
    issue(1'b0, alist[1], 8'h00);
    // A write straight after a read exercises the bus turnaround.
    issue(1'b1, alist[2], 8'($urandom));
    issue(1'b0, alist[2], 8'h00);
    repeat (20) @(negedge clk);
    cmp("reads left", 0, expq.size());
    test_done();
  end
endmodule
